/* swl_pkg.sv */
// shared constants, timing counts and helpers for the single wire link
`default_nettype none
package swl_pkg;
   // -------------------------------------------------------------
   // clock and conversion helpers
   // -------------------------------------------------------------
   localparam int CLK_NS = 50;

   // least time: round up, never below one cycle
   function automatic logic [13:0] cyc_min(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[13:0];
   endfunction

   // longest time: round down, never below one cycle
   function automatic logic [13:0] cyc_max(input int ns);
      int c;
      c = ns / CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[13:0];
   endfunction

   // reflected crc-16, poly x16+x15+x2+1, one bit at a time, lsb first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[0] ^ b;
      crc_step = {1'b0, c[15:1]} ^ (fb ? 16'ha001 : 16'h0000);
   endfunction

   // -------------------------------------------------------------
   // times in ns, as figures
   // -------------------------------------------------------------
   localparam int RST_LOW_STD_NS = 480000;
   localparam int RST_LOW_OD_NS = 70000;
   localparam int EDGE_FALL_ALLOW_NS = 500;
   localparam int RST_DET_STD_NS = 120000;
   localparam int RST_DET_OD_NS = 15500;
   localparam int RST_HIGH_STD_NS = 480000;
   localparam int RST_HIGH_OD_NS = 48000;
   localparam int PRES_WAIT_STD_NS = 30000;
   localparam int PRES_WAIT_OD_NS = 3000;
   localparam int PRES_LOW_STD_NS = 120000;
   localparam int PRES_LOW_OD_NS = 12000;
   localparam int PRES_SAMP_STD_NS = 70000;
   localparam int PRES_SAMP_OD_NS = 8500;
   localparam int W1_LOW_STD_NS = 6000;
   localparam int W1_LOW_OD_NS = 1000;
   localparam int W0_LOW_STD_NS = 60000;
   localparam int W0_LOW_OD_NS = 7500;
   localparam int HOST_SAMP_STD_NS = 12000;
   localparam int HOST_SAMP_OD_NS = 1500;
   localparam int DEV_SAMP_STD_NS = 15000;
   localparam int DEV_SAMP_OD_NS = 2000;
   localparam int DEV_HOLD_STD_NS = 30000;
   localparam int DEV_HOLD_OD_NS = 3000;
   localparam int SLOT_STD_NS = 86000;
   localparam int SLOT_OD_NS = 16000;

   // -------------------------------------------------------------
   // cycle counts
   // -------------------------------------------------------------
   localparam logic [13:0] RST_LOW_STD_CYC = cyc_min(RST_LOW_STD_NS);
   localparam logic [13:0] RST_LOW_OD_CYC = cyc_min(RST_LOW_OD_NS);
   localparam logic [13:0] EDGE_FALL_CYC = cyc_min(EDGE_FALL_ALLOW_NS);
   localparam logic [13:0] OD_CLEAR_CYC = cyc_min(RST_LOW_STD_NS);
   localparam logic [13:0] RST_DET_STD_CYC = cyc_max(RST_DET_STD_NS);
   localparam logic [13:0] RST_DET_OD_CYC = cyc_max(RST_DET_OD_NS);
   localparam logic [13:0] RST_HIGH_STD_CYC = cyc_min(RST_HIGH_STD_NS);
   localparam logic [13:0] RST_HIGH_OD_CYC = cyc_min(RST_HIGH_OD_NS);
   localparam logic [13:0] PRES_WAIT_STD_CYC = cyc_min(PRES_WAIT_STD_NS);
   localparam logic [13:0] PRES_WAIT_OD_CYC = cyc_min(PRES_WAIT_OD_NS);
   localparam logic [13:0] PRES_LOW_STD_CYC = cyc_min(PRES_LOW_STD_NS);
   localparam logic [13:0] PRES_LOW_OD_CYC = cyc_min(PRES_LOW_OD_NS);
   localparam logic [13:0] PRES_SAMP_STD_CYC = cyc_min(PRES_SAMP_STD_NS);
   localparam logic [13:0] PRES_SAMP_OD_CYC = cyc_min(PRES_SAMP_OD_NS);
   localparam logic [13:0] W1_LOW_STD_CYC = cyc_min(W1_LOW_STD_NS);
   localparam logic [13:0] W1_LOW_OD_CYC = cyc_min(W1_LOW_OD_NS);
   localparam logic [13:0] W0_LOW_STD_CYC = cyc_min(W0_LOW_STD_NS);
   localparam logic [13:0] W0_LOW_OD_CYC = cyc_min(W0_LOW_OD_NS);
   localparam logic [13:0] HOST_SAMP_STD_CYC = cyc_min(HOST_SAMP_STD_NS);
   localparam logic [13:0] HOST_SAMP_OD_CYC = cyc_min(HOST_SAMP_OD_NS);
   localparam logic [13:0] DEV_SAMP_STD_CYC = cyc_min(DEV_SAMP_STD_NS);
   localparam logic [13:0] DEV_SAMP_OD_CYC = cyc_min(DEV_SAMP_OD_NS);
   localparam logic [13:0] DEV_HOLD_STD_CYC = cyc_min(DEV_HOLD_STD_NS);
   localparam logic [13:0] DEV_HOLD_OD_CYC = cyc_min(DEV_HOLD_OD_NS);
   localparam logic [13:0] SLOT_STD_CYC = cyc_min(SLOT_STD_NS);
   localparam logic [13:0] SLOT_OD_CYC = cyc_min(SLOT_OD_NS);

   // -------------------------------------------------------------
   // codes
   // -------------------------------------------------------------
   localparam logic [7:0] CMD_SKIP = 8'hcc;
   localparam logic [7:0] CMD_OD_SKIP = 8'h3c;
   localparam logic [15:0] CRC_GOOD = 16'hb001;

   typedef enum logic [1:0] {
      OP_RESET = 2'b00,
      OP_WRITE = 2'b01,
      OP_READ = 2'b10
   } swl_op_e;
endpackage
`default_nettype wire

/* swl_link_if.sv */
// shared open-drain line between controller and peripheral
`timescale 1ns/10ps
`default_nettype none
interface swl_link_if;
   logic dev_o;
   logic dev_oe;
   logic host_o;
   logic host_oe;
   logic line;

   // pulled up; any enabled low driver wins
   assign line = ~((dev_oe & ~dev_o) | (host_oe & ~host_o));

   modport dev (input line, output dev_o, output dev_oe);
   modport host (input line, output host_o, output host_oe);
endinterface
`default_nettype wire

/* swl_dev.sv */
// peripheral end: reset/presence, speed, bit slots, command gating, crc
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - line driven only by open-drain pulldown
// - standard and overdrive bit rates supported
// - idle high; long low resets devices
// - controller orders init, address, function, data
// - reset pulse then device presence pulse
// - controller makes all falls except presence
// - standard speed unless placed in overdrive
// - overdrive uses fast timing for everything
// - slow-edge controller lengthens its reset low
// - reset of 480us or more clears overdrive
// - overdrive short reset keeps overdrive
// - mid-length overdrive reset: speed undetermined
// - after release, wait, then presence low
// - controller samples at presence sample time
// - ready once reset high time elapsed
// - mixed networks lengthen reset high time
// - function bytes only after reset and address
// - function data covered by crc-16
// - one bit per controller-started slot
// - addressing commands are 8-bit codes
// - overdrive skip sets overdrive until long reset
module swl_dev #(
   parameter logic [13:0] OD_CLEAR_CYC = swl_pkg::OD_CLEAR_CYC,
   parameter logic [13:0] RST_HIGH_STD_CYC = swl_pkg::RST_HIGH_STD_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // link
   swl_link_if.dev link,
   // received function-phase bytes
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_first_o,
   // byte to send in read slots
   input wire logic [7:0] tx_data_i,
   input wire logic tx_load_i,
   output logic tx_busy_o,
   // status
   input wire logic crc_clr_i,
   output logic crc_ok_o,
   output logic overdrive_o,
   output logic selected_o,
   output logic reset_seen_o
);
   typedef enum logic [2:0] {
      LS_IDLE = 3'b000,
      LS_SLOT = 3'b001,
      LS_PWAIT = 3'b010,
      LS_PLOW = 3'b011,
      LS_RSTH = 3'b100
   } swl_ls_e;

   typedef enum logic [1:0] {
      PH_WAIT = 2'b00,
      PH_ROM = 2'b01,
      PH_FUNC = 2'b10
   } swl_ph_e;

   typedef struct packed {
      logic s1;
      logic s2;
      swl_ls_e ls;
      swl_ph_e ph;
      logic [13:0] cnt;
      logic od;
      logic drv;
      logic pin;
      logic bitv;
      logic [7:0] sh;
      logic [2:0] bitn;
      logic [7:0] txsh;
      logic [3:0] txn;
      logic first;
      logic [15:0] crc;
      logic [7:0] rx_data;
      logic rx_valid;
      logic rx_first;
      logic tx_busy;
      logic crc_ok;
      logic sel;
      logic rst_seen;
   } swl_dev_s;

   swl_dev_s st;
   swl_dev_s next_st;
   logic [13:0] samp;
   logic [13:0] hold;
   logic [13:0] rstdet;
   logic [13:0] pwait;
   logic [13:0] plow;
   logic [13:0] rsth;
   logic lo;
   logic [7:0] byte_in;

   // -------------------------------------------------------------
   // speed-dependent timing
   // -------------------------------------------------------------
   always_comb begin
      samp = st.od ? swl_pkg::DEV_SAMP_OD_CYC : swl_pkg::DEV_SAMP_STD_CYC;
      hold = st.od ? swl_pkg::DEV_HOLD_OD_CYC : swl_pkg::DEV_HOLD_STD_CYC;
      rstdet = st.od ? swl_pkg::RST_DET_OD_CYC : swl_pkg::RST_DET_STD_CYC;
      pwait = st.od ? swl_pkg::PRES_WAIT_OD_CYC : swl_pkg::PRES_WAIT_STD_CYC;
      plow = st.od ? swl_pkg::PRES_LOW_OD_CYC : swl_pkg::PRES_LOW_STD_CYC;
      rsth = st.od ? swl_pkg::RST_HIGH_OD_CYC : RST_HIGH_STD_CYC;
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = link.line;
      next_st.s2 = st.s1;
      next_st.rx_valid = 1'b0;
      next_st.rst_seen = 1'b0;
      next_st.pin = 1'b0;
      lo = ~st.s2;
      byte_in = {st.bitv, st.sh[7:1]};
      if (crc_clr_i) begin
         next_st.crc = 16'h0000;
      end
      if (st.cnt != 14'h3fff) begin
         next_st.cnt = st.cnt + 14'h0001;
      end
      unique case (st.ls)
         LS_IDLE: begin
            if (tx_load_i && st.txn == 4'h0 && !lo) begin
               next_st.txsh = tx_data_i;
               next_st.txn = 4'h8;
            end
            if (lo) begin
               next_st.ls = LS_SLOT;
               next_st.cnt = 14'h0001;
               // read slot with a zero to send: hold the line down
               if (st.ph == PH_FUNC && st.txn != 4'h0 && !st.txsh[0]) begin
                  next_st.drv = 1'b1;
               end
            end
         end
         LS_SLOT: begin
            if (st.cnt == hold) begin
               next_st.drv = 1'b0;
            end
            if (st.cnt == samp) begin
               next_st.bitv = st.s2;
            end
            if (!lo && st.cnt > samp) begin
               if (st.cnt > rstdet) begin
                  next_st.ls = LS_PWAIT;
                  next_st.cnt = 14'h0000;
                  next_st.ph = PH_ROM;
                  next_st.bitn = 3'h0;
                  next_st.txn = 4'h0;
                  next_st.crc = 16'h0000;
                  next_st.drv = 1'b0;
                  next_st.rst_seen = 1'b1;
                  // shorter low in overdrive keeps speed; mid range keeps it too
                  if (st.cnt >= OD_CLEAR_CYC) begin
                     next_st.od = 1'b0;
                  end
               end else begin
                  next_st.ls = LS_IDLE;
                  if (st.ph == PH_FUNC && st.txn != 4'h0) begin
                     next_st.txn = st.txn - 4'h1;
                     next_st.txsh = {1'b1, st.txsh[7:1]};
                     next_st.crc = swl_pkg::crc_step(next_st.crc, st.bitv);
                  end else if (st.ph != PH_WAIT) begin
                     next_st.sh = byte_in;
                     next_st.bitn = st.bitn + 3'h1;
                     if (st.ph == PH_FUNC) begin
                        next_st.crc = swl_pkg::crc_step(next_st.crc, st.bitv);
                     end
                     if (st.bitn == 3'h7) begin
                        if (st.ph == PH_ROM) begin
                           if (byte_in == swl_pkg::CMD_SKIP) begin
                              next_st.ph = PH_FUNC;
                              next_st.first = 1'b1;
                           end else if (byte_in == swl_pkg::CMD_OD_SKIP) begin
                              next_st.ph = PH_FUNC;
                              next_st.first = 1'b1;
                              next_st.od = 1'b1;
                           end else begin
                              // unsupported selection: sit out until next reset
                              next_st.ph = PH_WAIT;
                           end
                        end else begin
                           next_st.rx_data = byte_in;
                           next_st.rx_valid = 1'b1;
                           next_st.rx_first = st.first;
                           next_st.first = 1'b0;
                        end
                     end
                  end
               end
            end
         end
         LS_PWAIT: begin
            if (st.cnt == pwait) begin
               next_st.ls = LS_PLOW;
               next_st.drv = 1'b1;
            end
         end
         LS_PLOW: begin
            if (st.cnt == pwait + plow) begin
               next_st.ls = LS_RSTH;
               next_st.drv = 1'b0;
            end
         end
         LS_RSTH: begin
            // falls seen here belong to other devices' presence
            if (st.cnt >= rsth) begin
               next_st.ls = LS_IDLE;
            end
         end
         default: begin
            next_st.ls = LS_IDLE;
         end
      endcase
      next_st.tx_busy = next_st.txn != 4'h0;
      next_st.crc_ok = next_st.crc == swl_pkg::CRC_GOOD;
      next_st.sel = next_st.ph == PH_FUNC;
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.s1 <= 1'b1;
         st.s2 <= 1'b1;
         st.txsh <= 8'hff;
      end else begin
         st <= next_st;
      end
   end

   assign link.dev_o = st.pin;
   assign link.dev_oe = st.drv;
   assign rx_data_o = st.rx_data;
   assign rx_valid_o = st.rx_valid;
   assign rx_first_o = st.rx_first;
   assign tx_busy_o = st.tx_busy;
   assign crc_ok_o = st.crc_ok;
   assign overdrive_o = st.od;
   assign selected_o = st.sel;
   assign reset_seen_o = st.rst_seen;
endmodule
`default_nettype wire

/* swl_host.sv */
// controller end: reset pulses, presence check and byte slots
`timescale 1ns/10ps
`default_nettype none
module swl_host #(
   parameter logic [13:0] RST_LOW_STD_CYC = swl_pkg::RST_LOW_STD_CYC,
   parameter logic [13:0] RST_HIGH_STD_CYC = swl_pkg::RST_HIGH_STD_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // link
   swl_link_if.host link,
   // command
   input wire logic start_i,
   input wire logic [1:0] op_i,
   input wire logic [7:0] wdata_i,
   input wire logic od_i,
   // answer
   output logic busy_o,
   output logic done_o,
   output logic [7:0] rdata_o,
   output logic presence_o,
   output logic [15:0] crc_o,
   output logic crc_ok_o
);
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_RLOW = 2'b01,
      HS_RREC = 2'b10,
      HS_SLOT = 2'b11
   } swl_hs_e;

   typedef struct packed {
      logic s1;
      logic s2;
      swl_hs_e hs;
      logic [13:0] cnt;
      logic od;
      logic drv;
      logic pin;
      logic [7:0] sh;
      logic [2:0] bitn;
      logic rbit;
      logic busy;
      logic done;
      logic [7:0] rdata;
      logic pres;
      logic [15:0] crc;
      logic crc_ok;
   } swl_host_s;

   swl_host_s st;
   swl_host_s next_st;
   logic [13:0] rlow;
   logic [13:0] rsth;
   logic [13:0] psamp;
   logic [13:0] w1;
   logic [13:0] w0;
   logic [13:0] hsamp;
   logic [13:0] slot;

   // -------------------------------------------------------------
   // speed-dependent timing
   // -------------------------------------------------------------
   always_comb begin
      // slow falling edge: reset low lengthened by the fall allowance
      rlow = (st.od ? swl_pkg::RST_LOW_OD_CYC : RST_LOW_STD_CYC) + swl_pkg::EDGE_FALL_CYC;
      rsth = st.od ? swl_pkg::RST_HIGH_OD_CYC : RST_HIGH_STD_CYC;
      psamp = st.od ? swl_pkg::PRES_SAMP_OD_CYC : swl_pkg::PRES_SAMP_STD_CYC;
      w1 = st.od ? swl_pkg::W1_LOW_OD_CYC : swl_pkg::W1_LOW_STD_CYC;
      w0 = st.od ? swl_pkg::W0_LOW_OD_CYC : swl_pkg::W0_LOW_STD_CYC;
      hsamp = st.od ? swl_pkg::HOST_SAMP_OD_CYC : swl_pkg::HOST_SAMP_STD_CYC;
      slot = st.od ? swl_pkg::SLOT_OD_CYC : swl_pkg::SLOT_STD_CYC;
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = link.line;
      next_st.s2 = st.s1;
      next_st.done = 1'b0;
      next_st.pin = 1'b0;
      next_st.cnt = st.cnt + 14'h0001;
      unique case (st.hs)
         HS_IDLE: begin
            next_st.cnt = 14'h0000;
            if (start_i) begin
               next_st.busy = 1'b1;
               next_st.od = od_i;
               next_st.drv = 1'b1;
               next_st.bitn = 3'h0;
               next_st.sh = (op_i == swl_pkg::OP_READ) ? 8'hff : wdata_i;
               if (op_i == swl_pkg::OP_RESET) begin
                  next_st.hs = HS_RLOW;
                  next_st.crc = 16'h0000;
               end else begin
                  next_st.hs = HS_SLOT;
               end
            end
         end
         HS_RLOW: begin
            if (st.cnt == rlow - 14'h0001) begin
               next_st.drv = 1'b0;
               next_st.hs = HS_RREC;
               next_st.cnt = 14'h0000;
            end
         end
         HS_RREC: begin
            if (st.cnt == psamp) begin
               next_st.pres = ~st.s2;
            end
            if (st.cnt == rsth) begin
               next_st.hs = HS_IDLE;
               next_st.busy = 1'b0;
               next_st.done = 1'b1;
            end
         end
         HS_SLOT: begin
            if (st.cnt == (st.sh[0] ? w1 : w0)) begin
               next_st.drv = 1'b0;
            end
            if (st.cnt == hsamp) begin
               next_st.rbit = st.s2;
            end
            if (st.cnt == slot - 14'h0001) begin
               next_st.crc = swl_pkg::crc_step(st.crc, st.rbit);
               next_st.sh = {st.rbit, st.sh[7:1]};
               next_st.bitn = st.bitn + 3'h1;
               if (st.bitn == 3'h7) begin
                  next_st.hs = HS_IDLE;
                  next_st.busy = 1'b0;
                  next_st.done = 1'b1;
                  next_st.rdata = {st.rbit, st.sh[7:1]};
               end else begin
                  next_st.cnt = 14'h0000;
                  next_st.drv = 1'b1;
               end
            end
         end
      endcase
      next_st.crc_ok = next_st.crc == swl_pkg::CRC_GOOD;
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.s1 <= 1'b1;
         st.s2 <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign link.host_o = st.pin;
   assign link.host_oe = st.drv;
   assign busy_o = st.busy;
   assign done_o = st.done;
   assign rdata_o = st.rdata;
   assign presence_o = st.pres;
   assign crc_o = st.crc;
   assign crc_ok_o = st.crc_ok;
endmodule
`default_nettype wire

/* swl_link_props.sv */
// assertions on the shared line between the two ends
`timescale 1ns/10ps
`default_nettype none
module swl_link_props #(
   parameter logic [13:0] RST_LOW_STD_CYC = swl_pkg::RST_LOW_STD_CYC,
   parameter logic [13:0] RST_HIGH_STD_CYC = swl_pkg::RST_HIGH_STD_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // line
   input wire logic dev_o,
   input wire logic dev_oe,
   input wire logic host_o,
   input wire logic host_oe,
   input wire logic line
);
   // ----
   // run lengths: host low, gap since release, last low
   // ----
   logic [13:0] h_cnt;
   logic [13:0] g_cnt;
   logic [13:0] r_len;
   logic [13:0] d_cnt;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         d_cnt <= 14'h0;
         h_cnt <= 14'h0;
         g_cnt <= 14'h0;
         r_len <= 14'h0;
      end else begin
         d_cnt <= dev_oe ? d_cnt + 14'h1 : 14'h0;
         h_cnt <= host_oe ? h_cnt + 14'h1 : 14'h0;
         // saturate so a long idle never wraps into a window
         g_cnt <= host_oe ? 14'h0 : ((g_cnt == 14'h3fff) ? g_cnt : g_cnt + 14'h1);
         if (!host_oe && h_cnt != 14'h0) begin
            r_len <= h_cnt;
         end
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   dev_pulldown_a: assert property (dev_oe |-> !dev_o) else $error("device drives line high");
   host_pulldown_a: assert property (host_oe |-> !host_o) else $error("host drives line high");
   // device lows never reach the length that resets other parties
   dev_low_limit_a: assert property (d_cnt <= swl_pkg::RST_DET_STD_CYC)
      else $error("device holds line low too long");
   host_fall_a: assert property ($rose(host_oe) |-> $past(line) && !$past(dev_oe))
      else $error("host pulls line while busy");
   presence_only_a: assert property ($rose(dev_oe) && $past(line) |-> r_len > 14'd1300 &&
      (g_cnt inside {[14'd58:14'd68], [14'd598:14'd608]})) else $error("device made a stray fall");
   presence_due_a: assert property ($fell(host_oe) && h_cnt > 14'd1300 |-> ##[50:620] dev_oe)
      else $error("no presence after reset");
   reset_length_a: assert property ($fell(host_oe) && h_cnt > 14'd1300 |->
      h_cnt == RST_LOW_STD_CYC + swl_pkg::EDGE_FALL_CYC || h_cnt == swl_pkg::RST_LOW_OD_CYC + swl_pkg::EDGE_FALL_CYC)
      else $error("reset low length wrong");
   reset_high_a: assert property ($rose(host_oe) && r_len > 14'd1300 |->
      g_cnt >= ((r_len > 14'd2000) ? RST_HIGH_STD_CYC : swl_pkg::RST_HIGH_OD_CYC))
      else $error("slot began inside reset high time");
endmodule
`default_nettype wire

/* tb_single_wire_reset_presence_link.sv */
// self-checking bench: host and device ends joined over the shared line
`timescale 1ns/10ps
`default_nettype none
module tb_single_wire_reset_presence_link;
   // shortened long counts; device clears overdrive at the host's standard low figure
   // reset high must outlast presence wait plus presence low, or the next slot lands on it
   localparam logic [13:0] RST_LOW = 14'hbc2;
   localparam logic [13:0] RST_HIGH = 14'hc80;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic start_i = 1'b0;
   logic [1:0] op_i = 2'h0;
   logic [7:0] wdata_i = 8'h00;
   logic od_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic tx_load_i = 1'b0;
   logic crc_clr_i = 1'b0;
   logic busy_o, done_o, presence_o, h_ok, rx_valid_o, rx_first_o, tx_busy_o, crc_ok_o, overdrive_o, selected_o;
   logic [7:0] rdata_o, rx_data_o, got_data, d;
   logic reset_seen_o;
   logic [15:0] h_crc, c, hc;
   logic got_first;
   int fail_count = 0;
   int checks = 0;
   int rx_cnt = 0;
   int rs_cnt = 0;
   int n0;
   int seed = 32'h1a6a;
   swl_link_if swl_link_if_i ();
   swl_host #(.RST_LOW_STD_CYC(RST_LOW), .RST_HIGH_STD_CYC(RST_HIGH)) swl_host_i (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .link(swl_link_if_i), .start_i(start_i), .op_i(op_i), .wdata_i(wdata_i), .od_i(od_i),
      .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .presence_o(presence_o), .crc_o(h_crc), .crc_ok_o(h_ok));
   swl_dev #(.OD_CLEAR_CYC(RST_LOW), .RST_HIGH_STD_CYC(RST_HIGH)) swl_dev_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .link(swl_link_if_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_first_o(rx_first_o),
      .tx_data_i(tx_data_i), .tx_load_i(tx_load_i), .tx_busy_o(tx_busy_o), .crc_clr_i(crc_clr_i),
      .crc_ok_o(crc_ok_o), .overdrive_o(overdrive_o), .selected_o(selected_o), .reset_seen_o(reset_seen_o));
   swl_link_props #(.RST_LOW_STD_CYC(RST_LOW), .RST_HIGH_STD_CYC(RST_HIGH)) swl_link_props_i (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .dev_o(swl_link_if_i.dev_o), .dev_oe(swl_link_if_i.dev_oe),
      .host_o(swl_link_if_i.host_o), .host_oe(swl_link_if_i.host_oe), .line(swl_link_if_i.line));
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      if (rx_valid_o === 1'b1) begin
         got_data <= rx_data_o;
         got_first <= rx_first_o;
         rx_cnt <= rx_cnt + 1;
      end
      if (reset_seen_o === 1'b1) begin
         rs_cnt <= rs_cnt + 1;
      end
   end
   // ----
   // tasks
   // ----
   task automatic complete_run();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp1(input logic g, input logic e);
      cmp8({7'h0, g}, {7'h0, e});
   endtask
   task automatic host_op(input logic [1:0] op, input logic [7:0] w, input logic od);
      int n;
      @(posedge ref_clk_i);
      start_i <= 1'b1;
      op_i <= op;
      wdata_i <= w;
      od_i <= od;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      for (n = 0; n < 20000 && done_o !== 1'b1; n++) @(posedge ref_clk_i);
      if (n == 20000) begin
         fail_count++;
         complete_run();
      end
   endtask
   // one-cycle strobe: load selects the transmit load, else the crc clear
   task automatic pulse(input logic load);
      @(posedge ref_clk_i);
      if (load) begin
         tx_load_i <= 1'b1;
      end else begin
         crc_clr_i <= 1'b1;
      end
      @(posedge ref_clk_i);
      tx_load_i <= 1'b0;
      crc_clr_i <= 1'b0;
   endtask
   // reflected crc-16 worked out bit by bit, lsb first
   function automatic logic [15:0] crc8(input logic [15:0] s, input logic [7:0] b);
      for (int i = 0; i < 8; i++) s = (s[0] ^ b[i]) ? ((s >> 1) ^ 16'ha001) : (s >> 1);
      return s;
   endfunction
   // ----
   // sequence
   // ----
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      host_op(swl_pkg::OP_RESET, 8'h00, 1'b0);
      cmp1(presence_o, 1'b1);
      cmp1(overdrive_o, 1'b0);
      host_op(swl_pkg::OP_WRITE, swl_pkg::CMD_SKIP, 1'b0);
      cmp1(selected_o, 1'b1);
      d = 8'($random(seed));
      host_op(swl_pkg::OP_WRITE, d, 1'b0);
      cmp8(got_data, d);
      cmp1(got_first, 1'b1);
      $display("test std_skip done");
      host_op(swl_pkg::OP_RESET, 8'h00, 1'b0);
      host_op(swl_pkg::OP_WRITE, swl_pkg::CMD_OD_SKIP, 1'b0);
      cmp1(overdrive_o, 1'b1);
      pulse(1'b0);
      d = 8'($random(seed));
      c = ~crc8(16'h0000, d);
      host_op(swl_pkg::OP_WRITE, d, 1'b1);
      cmp8(got_data, d);
      cmp1(got_first, 1'b1);
      host_op(swl_pkg::OP_WRITE, c[7:0], 1'b1);
      cmp1(got_first, 1'b0);
      host_op(swl_pkg::OP_WRITE, c[15:8], 1'b1);
      cmp1(crc_ok_o, 1'b1);
      // host crc runs over every slot since its last reset
      hc = crc8(crc8(crc8(crc8(16'h0000, swl_pkg::CMD_OD_SKIP), d), c[7:0]), c[15:8]);
      cmp8(h_crc[7:0], hc[7:0]);
      cmp8(h_crc[15:8], hc[15:8]);
      cmp1(h_ok, hc == swl_pkg::CRC_GOOD);
      d = 8'($random(seed));
      @(posedge ref_clk_i);
      tx_data_i <= d;
      pulse(1'b1);
      @(posedge ref_clk_i);
      cmp1(tx_busy_o, 1'b1);
      host_op(swl_pkg::OP_READ, 8'hff, 1'b1);
      cmp8(rdata_o, d);
      cmp1(tx_busy_o, 1'b0);
      $display("test od_crc_read done");
      // short reset at fast timing must keep overdrive
      host_op(swl_pkg::OP_RESET, 8'h00, 1'b1);
      cmp1(presence_o, 1'b1);
      cmp1(overdrive_o, 1'b1);
      host_op(swl_pkg::OP_WRITE, 8'h55, 1'b1);
      cmp1(selected_o, 1'b0);
      n0 = rx_cnt;
      host_op(swl_pkg::OP_WRITE, 8'($random(seed)), 1'b1);
      cmp8(8'(rx_cnt), 8'(n0));
      host_op(swl_pkg::OP_RESET, 8'h00, 1'b0);
      cmp1(overdrive_o, 1'b0);
      cmp1(presence_o, 1'b1);
      cmp1(busy_o, 1'b0);
      cmp8(8'(rs_cnt), 8'h04);
      $display("test resets done");
      complete_run();
   end
endmodule
`default_nettype wire
